// File: hw/iwd_regs.svh
// Register offsets, keys, reset values and field widths of the watchdog
`ifndef IWD_REGS_SVH
`define IWD_REGS_SVH
`define IWD_ADDR_W 4
`define IWD_OFF_KEY 4'h0
`define IWD_OFF_PRESCALE 4'h4
`define IWD_OFF_RELOAD 4'h8
`define IWD_OFF_STATUS 4'hc
`define IWD_KEY_W 16
`define IWD_KEY_RELOAD 16'haaaa
`define IWD_KEY_UNLOCK 16'h5555
`define IWD_KEY_ENABLE 16'hcccc
`define IWD_PRE_W 3
`define IWD_RELOAD_W 12
`define IWD_PRESCALE_RST 3'h0
`define IWD_RELOAD_RST 12'hfff
`define IWD_COUNT_ZERO 12'h000
`define IWD_COUNT_ONE 12'h001
`define IWD_BIT_PRE_PEND 0
`define IWD_BIT_RELOAD_PEND 1
`define IWD_PEND_W 2
`define IWD_DATA_ZERO 32'h0000_0000
`define IWD_PRE_CNT_W 8
`define IWD_PRE_BASE 8'h04
`define IWD_PRE_MAX 3'h7
`define IWD_PRE_TOP 8'hff
`define IWD_PRE_ONE 8'h01
`endif

// File: hw/iwd_pkg.sv
// Types shared by the watchdog design files
package iwd_pkg;
    typedef enum logic [2:0] {
        IWD_ST_OFF = 3'b001,
        IWD_ST_RUN = 3'b010,
        IWD_ST_BITE = 3'b100
    } iwd_state_type;
    typedef logic [11:0] iwd_count_type;
    typedef logic [2:0] iwd_prescale_type;
endpackage

// File: hw/iwd_prescaler.sv
// Prescaler dividing the low-speed tick by 4 up to 256
`include "iwd_regs.svh"
module iwd_prescaler (
    input wire logic clock,                     // System clock
    input wire logic sys_rst,                   // Async reset, high
    input wire logic tick_in,                   // Low-speed clock tick
    input wire logic run,                       // Counting allowed
    input wire logic restart,                   // Clear the phase
    input wire iwd_pkg::iwd_prescale_type select, // Division code
    output logic div_tick                       // Divided tick pulse
);
    import iwd_pkg::*;

    logic [`IWD_PRE_CNT_W-1:0] cnt_reg;
    logic [`IWD_PRE_CNT_W-1:0] cnt_next;
    logic [`IWD_PRE_CNT_W-1:0] term;
    logic at_term;

    // Last count of one divided period
    function automatic logic [`IWD_PRE_CNT_W-1:0] term_of(
        input iwd_prescale_type sel);
        logic [`IWD_PRE_CNT_W-1:0] base;
        base = `IWD_PRE_BASE << sel;
        if (sel == `IWD_PRE_MAX) begin
            term_of = `IWD_PRE_TOP;
        end else begin
            term_of = base - `IWD_PRE_ONE;
        end
    endfunction

    assign term = term_of(select);
    assign at_term = (cnt_reg == term);
    assign cnt_next = (restart || !run) ? '0 :
                      (!tick_in) ? cnt_reg :
                      at_term ? '0 : cnt_reg + `IWD_PRE_ONE;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            div_tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            div_tick <= run && !restart && tick_in && at_term;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_div_at_term;
        div_tick |-> $past(cnt_reg) == $past(term) && $past(tick_in);
    endproperty
    a_div_at_term: assert property (p_div_at_term)
        else $error("Divided tick outside its terminal count");
endmodule

// File: hw/iwd_watchdog.sv
// Independent watchdog: key port, protected registers, 12-bit counter
//
// Operation
// - 12-bit counter keeps counting in low power
// - Enabled watchdog resets system at zero
// - Enable key starts the counter
// - Hardware option starts watchdog after power-on
// - Enable key ignored when hardware enabled
// - Reload key refreshes counter from reload value
// - Unlock key opens prescaler and reload registers
// - Any other key closes the protection
// - Protected registers take writes only unlocked
// - Prescale codes divide by 4 to 256
// - Timeout is reload plus one ticks
// - Status bit 0 shows prescaler transfer
// - Status bit 1 shows reload transfer
// - Debug halt with freeze stops counter
// - Standby reset restores register values
//
// The plain strobed port was chosen for this implementation.
`include "iwd_regs.svh"
module iwd_watchdog (
    input wire logic clock,                   // 20 MHz system clock
    input wire logic sys_rst,                 // Async reset, high
    input wire logic [`IWD_ADDR_W-1:0] addr,  // Register byte address
    input wire logic [31:0] wr_data,          // Write data
    input wire logic wr_en,                   // Write strobe
    input wire logic rd_en,                   // Read strobe
    output logic [31:0] rd_data,              // Read data, next cycle
    input wire logic low_speed_rc_clock_tick, // One pulse per RC edge
    input wire logic hw_enable_option,        // Hardware enable strap
    input wire logic standby_reset,           // Standby reset pulse
    input wire logic debug_halt,              // Core halted in debug
    input wire logic debug_halt_freeze,       // Freeze in debug halt
    output logic watchdog_reset,              // System reset request
    output iwd_pkg::iwd_count_type wdg_count  // Current count
);
    import iwd_pkg::*;

    iwd_state_type state_reg;
    iwd_state_type state_next;
    logic boot_done_reg;
    logic hw_enabled_reg;
    logic unlocked_reg;
    logic unlocked_next;
    iwd_prescale_type prescale_reg;
    iwd_prescale_type act_prescale_reg;
    logic [`IWD_RELOAD_W-1:0] reload_reg;
    logic [`IWD_RELOAD_W-1:0] act_reload_reg;
    logic [`IWD_PEND_W-1:0] pend_reg;
    logic [`IWD_PEND_W-1:0] stage_reg;
    logic [`IWD_PEND_W-1:0] prot_wr;
    logic [`IWD_PEND_W-1:0] apply;
    logic en_req_reg;
    logic rl_req_reg;
    iwd_count_type count_reg;
    iwd_count_type count_next;
    logic [31:0] rd_value;
    logic lt;
    logic key_wr;
    logic key_enable;
    logic key_reload;
    logic key_unlock;
    logic frozen;
    logic running;
    logic div_tick;
    logic load_now;
    logic expire;

    // Key compare used by every command
    function automatic logic key_is(input logic [`IWD_KEY_W-1:0] v,
                                    input logic [`IWD_KEY_W-1:0] k);
        key_is = (v == k);
    endfunction

    assign lt = low_speed_rc_clock_tick;
    assign key_wr = wr_en && (addr == `IWD_OFF_KEY);
    assign key_enable = key_wr &&
                        key_is(wr_data[`IWD_KEY_W-1:0], `IWD_KEY_ENABLE);
    assign key_reload = key_wr &&
                        key_is(wr_data[`IWD_KEY_W-1:0], `IWD_KEY_RELOAD);
    assign key_unlock = key_wr &&
                        key_is(wr_data[`IWD_KEY_W-1:0], `IWD_KEY_UNLOCK);

    // Protection opens on unlock key, closes on any other key
    assign unlocked_next = standby_reset ? 1'b0 :
                           key_unlock ? 1'b1 :
                           key_wr ? 1'b0 :
                           unlocked_reg;

    // Writes to protected registers only while unlocked
    assign prot_wr[`IWD_BIT_PRE_PEND] = wr_en && unlocked_reg &&
                                        (addr == `IWD_OFF_PRESCALE);
    assign prot_wr[`IWD_BIT_RELOAD_PEND] = wr_en && unlocked_reg &&
                                        (addr == `IWD_OFF_RELOAD);

    // First tick of a pending transfer copies the value across
    assign apply = pend_reg & ~stage_reg & {`IWD_PEND_W{lt}} & ~prot_wr;

    assign frozen = debug_halt && debug_halt_freeze;
    assign running = (state_reg == IWD_ST_RUN) && !frozen;
    assign load_now = lt && (rl_req_reg || en_req_reg);
    assign expire = running && div_tick && (count_reg == `IWD_COUNT_ZERO);

    // Counter advances only on divided ticks, from the RC clock alone
    assign count_next = load_now ? act_reload_reg :
                        !(running && div_tick) ? count_reg :
                        expire ? count_reg :
                        count_reg - `IWD_COUNT_ONE;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IWD_ST_OFF: begin
                if (!boot_done_reg && hw_enable_option) begin
                    state_next = IWD_ST_RUN;
                end else if (lt && en_req_reg) begin
                    state_next = IWD_ST_RUN;
                end
            end
            IWD_ST_RUN: begin
                if (expire) begin
                    state_next = IWD_ST_BITE;
                end
            end
            IWD_ST_BITE: begin
                state_next = IWD_ST_BITE;
            end
            default: begin
                state_next = IWD_ST_OFF;
            end
        endcase
    end

    assign rd_value =
        (addr == `IWD_OFF_PRESCALE) ? {29'h0, prescale_reg} :
        (addr == `IWD_OFF_RELOAD) ? {20'h0, reload_reg} :
        (addr == `IWD_OFF_STATUS) ? {30'h0, pend_reg} :
        `IWD_DATA_ZERO;

    iwd_prescaler u_prescaler (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick_in(lt),
        .run(running),
        .restart(load_now),
        .select(act_prescale_reg),
        .div_tick(div_tick)
    );

    // Strap caught on the first clock after reset release
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            boot_done_reg <= 1'b0;
            hw_enabled_reg <= 1'b0;
        end else if (!boot_done_reg) begin
            boot_done_reg <= 1'b1;
            hw_enabled_reg <= hw_enable_option;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= IWD_ST_OFF;
            count_reg <= `IWD_RELOAD_RST;
            watchdog_reset <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            watchdog_reset <= (state_next == IWD_ST_BITE);
        end
    end

    // Commands wait for the next RC tick; a new key wins over the clear on that tick
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            en_req_reg <= 1'b0;
            rl_req_reg <= 1'b0;
        end else begin
            if (key_enable && !hw_enabled_reg && boot_done_reg &&
                state_reg == IWD_ST_OFF) begin
                en_req_reg <= 1'b1;
            end else if (lt) begin
                en_req_reg <= 1'b0;
            end
            if (key_reload) begin
                rl_req_reg <= 1'b1;
            end else if (lt) begin
                rl_req_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            unlocked_reg <= 1'b0;
        end else begin
            unlocked_reg <= unlocked_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prescale_reg <= `IWD_PRESCALE_RST;
            reload_reg <= `IWD_RELOAD_RST;
        end else if (standby_reset) begin
            prescale_reg <= `IWD_PRESCALE_RST;
            reload_reg <= `IWD_RELOAD_RST;
        end else begin
            if (prot_wr[`IWD_BIT_PRE_PEND]) begin
                prescale_reg <= wr_data[`IWD_PRE_W-1:0];
            end
            if (prot_wr[`IWD_BIT_RELOAD_PEND]) begin
                reload_reg <= wr_data[`IWD_RELOAD_W-1:0];
            end
        end
    end

    // Counter-side copies; kept through standby so counting goes on
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            act_prescale_reg <= `IWD_PRESCALE_RST;
            act_reload_reg <= `IWD_RELOAD_RST;
        end else begin
            if (apply[`IWD_BIT_PRE_PEND]) begin
                act_prescale_reg <= prescale_reg;
            end
            if (apply[`IWD_BIT_RELOAD_PEND]) begin
                act_reload_reg <= reload_reg;
            end
        end
    end

    // Two-tick handshake per flag: copy, then acknowledge
    genvar gi;
    generate
        for (gi = 0; gi < `IWD_PEND_W; gi = gi + 1) begin : g_pend
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    pend_reg[gi] <= 1'b0;
                    stage_reg[gi] <= 1'b0;
                end else if (standby_reset) begin
                    pend_reg[gi] <= 1'b0;
                    stage_reg[gi] <= 1'b0;
                end else if (prot_wr[gi]) begin
                    pend_reg[gi] <= 1'b1;
                    stage_reg[gi] <= 1'b0;
                end else if (lt && pend_reg[gi]) begin
                    pend_reg[gi] <= !stage_reg[gi];
                    stage_reg[gi] <= !stage_reg[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= `IWD_DATA_ZERO;
            wdg_count <= `IWD_RELOAD_RST;
        end else begin
            rd_data <= rd_en ? rd_value : `IWD_DATA_ZERO;
            wdg_count <= count_next;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_bite_on_zero;
        running && div_tick && count_reg == `IWD_COUNT_ZERO && !load_now
            |=> watchdog_reset && state_reg == IWD_ST_BITE;
    endproperty
    a_bite_on_zero: assert property (p_bite_on_zero)
        else $error("No reset after the count reached zero");

    property p_enable_key;
        key_enable && !hw_enabled_reg && boot_done_reg &&
            state_reg == IWD_ST_OFF && !standby_reset
            |=> en_req_reg;
    endproperty
    a_enable_key: assert property (p_enable_key)
        else $error("Enable key not taken");

    property p_hw_start;
        $rose(boot_done_reg) |-> (state_reg == IWD_ST_RUN) == hw_enabled_reg;
    endproperty
    a_hw_start: assert property (p_hw_start)
        else $error("Hardware enable option not followed");

    property p_hw_ignore;
        hw_enabled_reg && !en_req_reg |=> !en_req_reg;
    endproperty
    a_hw_ignore: assert property (p_hw_ignore)
        else $error("Enable key taken while hardware enabled");

    property p_reload_req;
        key_reload |=> rl_req_reg;
    endproperty
    a_reload_req: assert property (p_reload_req)
        else $error("Reload key not taken");

    property p_reload_load;
        lt && rl_req_reg |=> count_reg == $past(act_reload_reg);
    endproperty
    a_reload_load: assert property (p_reload_load)
        else $error("Counter not reloaded on the tick");

    property p_unlock;
        key_unlock && !standby_reset |=> unlocked_reg;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("Unlock key did not open protection");

    property p_relock;
        key_wr && !key_unlock |=> !unlocked_reg;
    endproperty
    a_relock: assert property (p_relock)
        else $error("Other key did not close protection");

    property p_protected;
        wr_en && !unlocked_reg && !standby_reset
            |=> $stable(prescale_reg) && $stable(reload_reg);
    endproperty
    a_protected: assert property (p_protected)
        else $error("Protected register changed while locked");

    property p_pre_pend;
        prot_wr[`IWD_BIT_PRE_PEND] && !standby_reset
            |=> pend_reg[`IWD_BIT_PRE_PEND];
    endproperty
    a_pre_pend: assert property (p_pre_pend)
        else $error("Prescaler pending flag not set");

    property p_reload_pend;
        prot_wr[`IWD_BIT_RELOAD_PEND] && !standby_reset
            |=> pend_reg[`IWD_BIT_RELOAD_PEND];
    endproperty
    a_reload_pend: assert property (p_reload_pend)
        else $error("Reload pending flag not set");

    property p_freeze;
        frozen && !load_now |=> $stable(count_reg);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("Counter moved during debug freeze");

    property p_standby;
        standby_reset |=> reload_reg == `IWD_RELOAD_RST && pend_reg == '0;
    endproperty
    a_standby: assert property (p_standby)
        else $error("Standby reset left registers changed");

    property p_stay_on;
        state_reg != IWD_ST_OFF |=> state_reg != IWD_ST_OFF;
    endproperty
    a_stay_on: assert property (p_stay_on)
        else $error("Watchdog stopped after enable");

    c_bite: cover property (running ##[1:1000] watchdog_reset);
    c_unlock_write: cover property (key_unlock ##1 prot_wr != '0);
    c_pend_done: cover property (pend_reg != '0 ##[1:1000] pend_reg == '0);
    c_freeze: cover property (frozen && running);
endmodule

// File: verif/tb_iwd_watchdog.sv
// Self-checking testbench for the independent watchdog
`include "iwd_regs.svh"
module tb_iwd_watchdog;
    timeunit 1ns;
    timeprecision 1ns;
    import iwd_pkg::*;

    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [`IWD_ADDR_W-1:0] addr = 4'h0;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rd_data;
    logic tick = 1'b0;
    logic hw_en = 1'b0;
    logic standby = 1'b0;
    logic halt = 1'b0;
    logic freeze = 1'b0;
    logic watchdog_reset;
    iwd_count_type wdg_count;
    int num_errors = 0;
    int checks_done = 0;

    iwd_watchdog iwd_watchdog_i (
        .clock(clock),
        .sys_rst(sys_rst),
        .addr(addr),
        .wr_data(wr_data),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .low_speed_rc_clock_tick(tick),
        .hw_enable_option(hw_en),
        .standby_reset(standby),
        .debug_halt(halt),
        .debug_halt_freeze(freeze),
        .watchdog_reset(watchdog_reset),
        .wdg_count(wdg_count)
    );

    always #25 clock = ~clock;

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp,
                       input string what);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        check(rd_data, exp, what);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clock);
            tick <= 1'b1;
            @(posedge clock);
            tick <= 1'b0;
        end
    endtask

    task automatic bite(input logic exp);
        repeat (4) @(posedge clock);
        @(negedge clock);
        check({31'h0, watchdog_reset}, {31'h0, exp}, "reset request");
    endtask

    task automatic rst_dut(input logic hw);
        @(posedge clock);
        hw_en <= hw;
        sys_rst <= 1'b1;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
    endtask

    task automatic key(input logic [15:0] k);
        wr(`IWD_OFF_KEY, {16'h0, k});
    endtask

    // Program divider and reload, enable, then pass the load tick
    task automatic setup(input logic [2:0] pre, input logic [11:0] reload);
        key(`IWD_KEY_UNLOCK);
        wr(`IWD_OFF_PRESCALE, {29'h0, pre});
        wr(`IWD_OFF_RELOAD, {20'h0, reload});
        ticks(2);
        key(`IWD_KEY_ENABLE);
        ticks(1);
    endtask

    task automatic pulse_standby;
        @(posedge clock);
        standby <= 1'b1;
        @(posedge clock);
        standby <= 1'b0;
    endtask

    task automatic expect_timeout(input int n);
        ticks(n - 2);
        bite(1'b0);
        ticks(3);
        bite(1'b1);
    endtask

    initial begin
        #(50 * 60000);
        num_errors++;
        $display("BAD %0t run did not finish in time", $time);
        wrap_up();
    end

    initial begin
        int dv;
        rst_dut(1'b0);
        @(negedge clock);
        // Reset values, key and unmapped reads
        check({20'h0, wdg_count}, {20'h0, `IWD_RELOAD_RST}, "count");
        rdc(`IWD_OFF_KEY, 32'h0, "key read");
        rdc(`IWD_OFF_PRESCALE, 32'h0, "prescale rst");
        rdc(`IWD_OFF_RELOAD, 32'h0000_0fff, "reload rst");
        rdc(`IWD_OFF_STATUS, 32'h0, "status rst");
        wr(4'h2, 32'hffff_ffff);
        rdc(4'h2, 32'h0, "unmapped");
        ticks(40);
        bite(1'b0);
        // Protection and update flags
        wr(`IWD_OFF_RELOAD, 32'h5);
        rdc(`IWD_OFF_RELOAD, 32'h0000_0fff, "locked write");
        key(`IWD_KEY_UNLOCK);
        wr(`IWD_OFF_RELOAD, 32'h3);
        rdc(`IWD_OFF_STATUS, 32'h2, "reload pending");
        wr(`IWD_OFF_PRESCALE, 32'h5);
        rdc(`IWD_OFF_STATUS, 32'h3, "both pending");
        ticks(2);
        rdc(`IWD_OFF_STATUS, 32'h0, "pending done");
        rdc(`IWD_OFF_RELOAD, 32'h3, "reload set");
        rdc(`IWD_OFF_PRESCALE, 32'h5, "prescale set");
        key(16'h1234);
        wr(`IWD_OFF_RELOAD, 32'h7);
        rdc(`IWD_OFF_RELOAD, 32'h3, "relock other");
        key(`IWD_KEY_UNLOCK);
        key(`IWD_KEY_RELOAD);
        wr(`IWD_OFF_PRESCALE, 32'h1);
        rdc(`IWD_OFF_PRESCALE, 32'h5, "relock reload");
        key(`IWD_KEY_UNLOCK);
        pulse_standby();
        rdc(`IWD_OFF_PRESCALE, 32'h0, "standby pre");
        rdc(`IWD_OFF_RELOAD, 32'h0000_0fff, "standby reload");
        wr(`IWD_OFF_RELOAD, 32'h9);
        rdc(`IWD_OFF_RELOAD, 32'h0000_0fff, "standby lock");
        // Every divider code with the shortest useful reload
        for (int c = 0; c < 8; c++) begin
            dv = (c >= 6) ? 256 : (4 << c);
            rst_dut(1'b0);
            setup(c[2:0], 12'h1);
            expect_timeout(2 * dv);
        end
        // Refresh postpones the bite; other keys do not stop it
        rst_dut(1'b0);
        setup(3'h0, 12'h3);
        ticks(12);
        key(`IWD_KEY_RELOAD);
        ticks(1);
        @(negedge clock);
        check({20'h0, wdg_count}, 32'h3, "refresh count");
        key(16'h0000);
        key(`IWD_KEY_UNLOCK);
        expect_timeout(16);
        // Debug freeze holds the count; standby does not stop it
        rst_dut(1'b0);
        setup(3'h0, 12'h3);
        ticks(5);
        halt <= 1'b1;
        freeze <= 1'b1;
        ticks(40);
        bite(1'b0);
        freeze <= 1'b0;
        pulse_standby();
        ticks(9);
        bite(1'b0);
        ticks(3);
        bite(1'b1);
        halt <= 1'b0;
        // Hardware enable starts from full count, enable key ignored
        rst_dut(1'b1);
        key(`IWD_KEY_UNLOCK);
        wr(`IWD_OFF_RELOAD, 32'h3);
        ticks(2);
        key(`IWD_KEY_ENABLE);
        ticks(100);
        bite(1'b0);
        ticks(4096 * 4 - 104);
        bite(1'b0);
        ticks(3);
        bite(1'b1);
        wrap_up();
    end
endmodule
